// ==== cmp_event_pkg.sv ====
// Package: register map, field layout and encodings of the event conditioner
package cmp_event_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] MASK_OFS = 4'h8;
    localparam logic [3:0] RAW_OFS = 4'hC;
    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int INV_BIT = 1;
    localparam int INTERRUPT_SENSE_SELECT_LO = 2;
    localparam int INTERRUPT_SENSE_SELECT_HI = 3;
    localparam int ILVL_BIT = 4;
    localparam int TRIGGER_SENSE_SELECT_LO = 5;
    localparam int TRIGGER_SENSE_SELECT_HI = 6;
    localparam int TLVL_BIT = 7;
    // Writable control bits 7:1; bit 0 reserved and reads zero
    localparam logic [31:0] CTRL_WMASK = 32'h0000_00FE;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // Status / mask bits: 0 interrupt event, 1 trigger event
    localparam int EV_IRQ = 0;
    localparam int EV_TRG = 1;
    localparam logic [1:0] EV_RST = 2'h0;
    // ------------------------------------------------------------
    // Sense encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SENSE_LEVEL = 2'b00,
        SENSE_FALL = 2'b01,
        SENSE_RISE = 2'b10,
        SENSE_BOTH = 2'b11
    } sense_t;
endpackage : cmp_event_pkg

// ==== sense_select.sv ====
// Sense selector: level or edge qualification of the conditioned output
`timescale 1ns/1ps
module sense_select (
    // Conditioned comparator and edges
    input wire logic level,
    input wire logic rise,
    input wire logic fall,
    // Configuration
    input wire cmp_event_pkg::sense_t mode,
    input wire logic activeLevel,
    // Result
    output logic hit
);
    // Level match or chosen transition
    wire levelHit = (level == activeLevel);
    always_comb begin
        unique case (mode)
            cmp_event_pkg::SENSE_LEVEL: hit = levelHit;
            cmp_event_pkg::SENSE_FALL: hit = fall;
            cmp_event_pkg::SENSE_RISE: hit = rise;
            cmp_event_pkg::SENSE_BOTH: hit = rise | fall;
        endcase
    end
endmodule : sense_select

// ==== comparator_event_conditioner.sv ====
// Comparator event conditioner: inversion, sense selection, Avalon regs
`timescale 1ns/1ps
module comparator_event_conditioner (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Comparator and event outputs
    input wire logic cmpOut,
    output logic adcTrigger,
    output logic cmpIrq,
    output logic irq
);
    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    logic cmpMeta_r;
    logic cmpSync_r;
    logic condPrev_r;
    always_ff @(posedge sys_clk) begin
        cmpMeta_r <= cmpOut;
        cmpSync_r <= cmpMeta_r;
    end

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic ackDone_r;
    // One wait state per access keeps readdata registered
    wire access = (read | write) & ~ackDone_r;
    // Writes land only at the edge that ends the access, one cycle after the wait state
    wire take = write & ackDone_r;
    wire [31:0] beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
        {8{byteenable[1]}}, {8{byteenable[0]}}};
    wire wrCtrl = take & (address == cmp_event_pkg::CTRL_OFS);
    wire wrStat = take & (address == cmp_event_pkg::STAT_OFS);
    wire wrMask = take & (address == cmp_event_pkg::MASK_OFS);
    wire [31:0] ctrl_nxt = (ctrl_r & ~beMask)
        | (writedata & beMask & cmp_event_pkg::CTRL_WMASK);
    assign waitrequest = (read | write) & ~ackDone_r;

    // ------------------------------------------------------------
    // Conditioning
    // ------------------------------------------------------------
    // invert before sensing
    wire cond = cmpSync_r ^ ctrl_r[cmp_event_pkg::INV_BIT];
    wire rise = cond & ~condPrev_r;
    wire fall = ~cond & condPrev_r;
    logic irqHit;
    logic trgHit;
    // Sense fields as enum values, shared by selectors and checks
    cmp_event_pkg::sense_t irqMode;
    cmp_event_pkg::sense_t trgMode;
    assign irqMode = cmp_event_pkg::sense_t'(
        ctrl_r[cmp_event_pkg::INTERRUPT_SENSE_SELECT_HI:cmp_event_pkg::INTERRUPT_SENSE_SELECT_LO]);
    assign trgMode = cmp_event_pkg::sense_t'(
        ctrl_r[cmp_event_pkg::TRIGGER_SENSE_SELECT_HI:cmp_event_pkg::TRIGGER_SENSE_SELECT_LO]);
    sense_select irqSel (
        .level(cond),
        .rise(rise),
        .fall(fall),
        .mode(irqMode),
        .activeLevel(ctrl_r[cmp_event_pkg::ILVL_BIT]),
        .hit(irqHit)
    );
    sense_select trgSel (
        .level(cond),
        .rise(rise),
        .fall(fall),
        .mode(trgMode),
        .activeLevel(ctrl_r[cmp_event_pkg::TLVL_BIT]),
        .hit(trgHit)
    );
    wire [1:0] evHit = {trgHit, irqHit};
    // Set beats write-one-to-clear in the same cycle
    wire [1:0] stat_nxt = (stat_r & ~(wrStat ? writedata[1:0] : 2'h0))
        | evHit;

    // Read mux
    logic [31:0] rdMux;
    always_comb begin
        unique case (address)
            cmp_event_pkg::CTRL_OFS: rdMux = ctrl_r;
            cmp_event_pkg::STAT_OFS: rdMux = {30'h0, stat_r};
            cmp_event_pkg::MASK_OFS: rdMux = {30'h0, mask_r};
            cmp_event_pkg::RAW_OFS: rdMux = {30'h0, evHit};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // previous conditioned value
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            condPrev_r <= 1'b0;
            ackDone_r <= 1'b0;
            readdata <= 32'h0000_0000;
        end else begin
            condPrev_r <= cond;
            ackDone_r <= access;
            if (access & read) begin
                readdata <= rdMux;
            end
        end
    end

    // Control, status and mask
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_r <= cmp_event_pkg::CTRL_RST;
            stat_r <= cmp_event_pkg::EV_RST;
            mask_r <= cmp_event_pkg::EV_RST;
        end else begin
            if (wrCtrl) begin
                ctrl_r <= ctrl_nxt;
            end
            stat_r <= stat_nxt;
            if (wrMask & byteenable[0]) begin
                mask_r <= writedata[1:0];
            end
        end
    end

    // Event outputs registered for clean edges
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            adcTrigger <= 1'b0;
            cmpIrq <= 1'b0;
        end else begin
            adcTrigger <= trgHit;
            cmpIrq <= irqHit;
        end
    end
    assign irq = |(stat_r & mask_r);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // Trigger sense selection
    trig_level_a: assert property (
        trgMode == cmp_event_pkg::SENSE_LEVEL |=> adcTrigger == $past(
            cond == ctrl_r[cmp_event_pkg::TLVL_BIT]))
        else $error("trigger level sense wrong");
    trig_rise_a: assert property (
        trgMode == cmp_event_pkg::SENSE_RISE && rise |=> adcTrigger)
        else $error("trigger missed rising edge");
    trig_fall_a: assert property (
        trgMode == cmp_event_pkg::SENSE_FALL && !fall |=> !adcTrigger)
        else $error("trigger fired without falling edge");
    trig_both_a: assert property (
        trgMode == cmp_event_pkg::SENSE_BOTH |=> adcTrigger == $past(
            rise | fall))
        else $error("trigger either edge wrong");
    // Interrupt sense selection
    irq_level_a: assert property (
        irqMode == cmp_event_pkg::SENSE_LEVEL
            && ctrl_r[cmp_event_pkg::ILVL_BIT] && cond |=> cmpIrq)
        else $error("interrupt level sense wrong");
    irq_low_a: assert property (
        irqMode == cmp_event_pkg::SENSE_LEVEL
            && !ctrl_r[cmp_event_pkg::ILVL_BIT] && !cond |=> cmpIrq)
        else $error("interrupt low level sense wrong");
    irq_fall_a: assert property (
        irqMode == cmp_event_pkg::SENSE_FALL && fall |=> cmpIrq)
        else $error("interrupt missed falling edge");
    irq_both_a: assert property (
        irqMode == cmp_event_pkg::SENSE_BOTH |=> cmpIrq == $past(
            rise | fall))
        else $error("interrupt either edge wrong");
    // Inversion judged from the raw sample, not from cond itself
    invert_path_a: assert property (
        ctrl_r[cmp_event_pkg::INV_BIT]
            && irqMode == cmp_event_pkg::SENSE_LEVEL
            && ctrl_r[cmp_event_pkg::ILVL_BIT] == cmpSync_r |=> !cmpIrq)
        else $error("inversion not applied");
    resv_zero_a: assert property (
        read && !waitrequest && address == cmp_event_pkg::CTRL_OFS
            |-> (readdata & ~cmp_event_pkg::CTRL_WMASK) == 32'h0000_0000)
        else $error("reserved control bits read nonzero");
    edge_once_a: assert property (
        irqMode == cmp_event_pkg::SENSE_RISE && rise
            |=> cmpIrq ##1 !cmpIrq)
        else $error("edge lasted over one cycle");
    // Status, interrupt and bus timing
    sticky_set_a: assert property (
        irqHit |=> stat_r[cmp_event_pkg::EV_IRQ])
        else $error("status event lost");
    stat_clear_a: assert property (
        wrStat && writedata[cmp_event_pkg::EV_IRQ] && !irqHit
            |=> !stat_r[cmp_event_pkg::EV_IRQ])
        else $error("status bit not cleared");
    irq_mask_a: assert property (
        stat_r[cmp_event_pkg::EV_TRG] && mask_r[cmp_event_pkg::EV_TRG]
            |-> irq)
        else $error("unmasked status gave no interrupt");
    wait_one_a: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("more than one wait state");

    // Main scenarios
    rise_trig_c: cover property (
        trgMode == cmp_event_pkg::SENSE_RISE ##1 adcTrigger);
    irq_out_c: cover property (!irq ##1 irq);
    clear_c: cover property (wrStat ##1 !stat_r[cmp_event_pkg::EV_IRQ]);
    fall_irq_c: cover property (irqMode == cmp_event_pkg::SENSE_FALL && fall);
    level_trig_c: cover property (trgMode == cmp_event_pkg::SENSE_LEVEL);
endmodule : comparator_event_conditioner

// ==== comparator_model.sv ====
// Comparator model: drives the raw comparator output into the block
`timescale 1ns/1ps
module comparator_model (
    // Clock
    input wire logic sys_clk,
    // Requested decision and comparator output
    input wire logic wantHigh,
    output logic cmpOut
);
    // Output moves on the clock edge so it never races the bench
    initial cmpOut = 1'b0;
    always @(posedge sys_clk) begin
        cmpOut <= wantHigh;
    end
endmodule : comparator_model

// ==== comparator_event_conditioner_bench.sv ====
// Bench: register access and event checks of the conditioner
`timescale 1ns/1ps
module comparator_event_conditioner_bench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, rd;
    logic waitrequest, cmpOut, adcTrigger, cmpIrq, irq;
    logic wantHigh = 1'b0;
    logic [3:0] byteenable = 4'hF;
    int n_errors = 0;
    int n_checks = 0;
    int nTrg = 0;
    int nIrq = 0;
    int c0, i0;
    logic [31:0] e;
    always #12.5 sys_clk = ~sys_clk;
    // Cycles high per output; equals event count only for 1-cycle pulses
    always @(posedge sys_clk) begin
        nTrg <= nTrg + int'(adcTrigger === 1'b1);
        nIrq <= nIrq + int'(cmpIrq === 1'b1);
    end
    comparator_model u_comparator_model (.sys_clk(sys_clk),
        .wantHigh(wantHigh), .cmpOut(cmpOut));
    comparator_event_conditioner u_comparator_event_conditioner (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .cmpOut(cmpOut),
        .adcTrigger(adcTrigger), .cmpIrq(cmpIrq), .irq(irq));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic wrap_up;
        if (n_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One Avalon access; the slave decides how long it waits
    task automatic access(input logic wr, input logic [3:0] a,
                          input logic [31:0] d);
        @(posedge sys_clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : access
    // Settle, then compare both event outputs
    task automatic outs(input logic [1:0] exp);
        repeat (6) @(posedge sys_clk);
        chk({30'h0, adcTrigger, cmpIrq}, {30'h0, exp});
    endtask : outs
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        access(1'b0, cmp_event_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        // level sense, low then high, then inverted
        outs(2'b11);
        access(1'b0, cmp_event_pkg::RAW_OFS, 32'h0);
        chk(rd, 32'h0000_0003);
        access(1'b1, cmp_event_pkg::CTRL_OFS, 32'h0000_0090);
        outs(2'b00);
        wantHigh <= 1'b1;
        outs(2'b11);
        access(1'b1, cmp_event_pkg::CTRL_OFS, 32'h0000_0092);
        outs(2'b00);
        wantHigh <= 1'b0;
        // reserved bit reads zero; unmapped place reads zero
        access(1'b1, cmp_event_pkg::CTRL_OFS, 32'hFFFF_FFFF);
        access(1'b0, cmp_event_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h0000_00FE);
        // Disabled byte lanes leave the control register alone
        byteenable <= 4'h0;
        access(1'b1, cmp_event_pkg::CTRL_OFS, 32'h0);
        byteenable <= 4'hF;
        access(1'b0, cmp_event_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h0000_00FE);
        access(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        access(1'b1, cmp_event_pkg::MASK_OFS, 32'h0000_0003);
        // every edge mode, plain and inverted
        for (int m = 1; m < 4; m++) begin
            for (int v = 0; v < 2; v++) begin
                e = 32'(v << 1) | 32'(m << 2) | 32'(m << 5);
                access(1'b1, cmp_event_pkg::CTRL_OFS, e);
                repeat (6) @(posedge sys_clk);
                access(1'b1, cmp_event_pkg::STAT_OFS, 32'h0000_0003);
                c0 = nTrg;
                i0 = nIrq;
                wantHigh <= 1'b1;
                repeat (8) @(posedge sys_clk);
                e = 32'((v == 1) ? m % 2 : m / 2);
                chk(32'(nTrg - c0), e);
                chk(32'(nIrq - i0), e);
                c0 = nTrg;
                i0 = nIrq;
                wantHigh <= 1'b0;
                repeat (8) @(posedge sys_clk);
                e = 32'((v == 1) ? m / 2 : m % 2);
                chk(32'(nTrg - c0), e);
                chk(32'(nIrq - i0), e);
            end
        end
        // Sticky status, write-one clear and masking of irq
        access(1'b0, cmp_event_pkg::STAT_OFS, 32'h0);
        chk(rd, 32'h0000_0003);
        access(1'b1, cmp_event_pkg::STAT_OFS, 32'h0000_0001);
        access(1'b0, cmp_event_pkg::STAT_OFS, 32'h0);
        chk(rd, 32'h0000_0002);
        chk({31'h0, irq}, 32'h1);
        access(1'b1, cmp_event_pkg::MASK_OFS, 32'h0);
        @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        wrap_up();
    end
    // Watchdog; the whole sequence needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge sys_clk);
        n_errors++;
        wrap_up();
    end
endmodule : comparator_event_conditioner_bench
